// File: src/eod_cost_mul.sv
`timescale 1ns/10ps
// One cycle type's count times its state cost
module eod_cost_mul
  import eod_pkg::*;
(
  input  wire logic [CNT_W-1:0]   count_i,
  input  wire logic [COST_W-1:0]  cost_i,
  output logic      [TOTAL_W-1:0] states_o
);

  assign states_o = TOTAL_W'(count_i) * TOTAL_W'(cost_i);

endmodule

// File: src/eod_decoder.sv
`timescale 1ns/10ps
module eod_decoder
  import eod_pkg::*;
#(
  parameter logic [COST_W-1:0] S_BRANCH_MEM = S_OTHER_DEF,
  parameter logic [COST_W-1:0] S_STACK_MEM  = S_OTHER_DEF,
  parameter logic [COST_W-1:0] S_BYTE_MEM   = S_OTHER_DEF,
  parameter logic [COST_W-1:0] S_WORD_MEM   = S_OTHER_DEF
)
(
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               srst_i,
  // Instruction in
  input  wire logic               instr_valid_i,
  input  wire logic [INSTR_W-1:0] instr_i,
  // Byte operand location
  input  wire logic               byte_periph_i,
  input  wire logic               byte_periph_slow_i,
  // Decode result
  output logic                    dec_valid_o,
  output logic                    dec_illegal_o,
  output eod_dec_t                dec_o,
  output eod_cnt_t                cnt_o,
  output logic      [TOTAL_W-1:0] exec_states_o
);

  // Byte and nibble split
  wire logic [7:0] byte1   = instr_i[31:24];
  wire logic [7:0] byte2   = instr_i[23:16];
  wire logic [3:0] nib_ch  = instr_i[15:12];
  wire logic [3:0] nib_cl  = instr_i[11:8];
  wire logic [3:0] fourth_byte_upper_nibble = instr_i[7:4];
  wire logic       second_sel = fourth_byte_upper_nibble[3];

  // Form recognition
  wire logic is_pfx1  = byte1 == PFX_FIRST;
  wire logic is_ctl   = is_pfx1 && byte2 == PFX_CTL && nib_ch == NIB_6;
  wire logic is_mul   = is_pfx1 && byte2 == PFX_MUL && nib_ch == NIB_5;
  wire logic is_div   = is_pfx1 && byte2 == PFX_DIV && nib_ch == NIB_5;
  wire logic is_log   = is_pfx1 && byte2 == PFX_LOG && nib_ch == NIB_6;
  wire logic ch_bit   = nib_ch == NIB_6 || nib_ch == NIB_7;
  wire logic is_reg_b = (byte1 == BIT_REG_T || byte1 == BIT_REG_M)
                        && byte2[3:0] == NIB_0 && ch_bit;
  wire logic is_abs_b = (byte1 == BIT_ABS_T || byte1 == BIT_ABS_M) && ch_bit;
  wire logic grp_test = byte1 == BIT_REG_T || byte1 == BIT_ABS_T;
  wire logic is_bit   = is_reg_b || is_abs_b;
  wire logic ch_seven = nib_ch == NIB_7;

  // Control transfer uses odd low nibbles only
  wire eod_op_t op_ctl =
    !nib_cl[0]  ? OP_NONE :
    second_sel  ? OP_STORE_CTL : OP_LOAD_CTL;

  wire eod_op_t op_mul =
    nib_cl == CL_MUL_B ? OP_SMUL_B :
    nib_cl == CL_MUL_W ? OP_SMUL_W : OP_NONE;

  wire eod_op_t op_div =
    nib_cl == CL_DIV_B ? OP_SDIV_B :
    nib_cl == CL_DIV_W ? OP_SDIV_W : OP_NONE;

  wire eod_op_t op_log =
    nib_cl == CL_OR  ? OP_OR_L  :
    nib_cl == CL_XOR ? OP_XOR_L :
    nib_cl == CL_AND ? OP_AND_L : OP_NONE;

  // Test-and-combine bit group, pairs share one cell
  wire eod_op_t op_btest =
    nib_cl == CL_TEST ? OP_BIT_TEST :
    !ch_seven         ? OP_NONE :
    nib_cl == CL_OR   ? (second_sel ? OP_BIT_OR_INV   : OP_BIT_OR)   :
    nib_cl == CL_XOR  ? (second_sel ? OP_BIT_XOR_INV  : OP_BIT_XOR)  :
    nib_cl == CL_AND  ? (second_sel ? OP_BIT_AND_INV  : OP_BIT_AND)  :
    nib_cl == CL_LOAD ? (second_sel ? OP_BIT_LOAD_INV : OP_BIT_LOAD) :
    OP_NONE;

  // Modify bit group
  wire eod_op_t op_bmod =
    nib_cl == CL_SET ? OP_BIT_SET :
    nib_cl == CL_NOT ? OP_BIT_NOT :
    nib_cl == CL_CLR ? OP_BIT_CLR :
    (nib_cl == CL_STORE && !ch_seven) ?
      (second_sel ? OP_BIT_STORE_INV : OP_BIT_STORE) :
    OP_NONE;

  // Test group on even first bytes, modify group on odd ones
  wire eod_op_t op_bit = grp_test ? op_btest : op_bmod;

  // Form recognisers are mutually exclusive
  wire eod_op_t op_d =
    is_ctl ? op_ctl :
    is_mul ? op_mul :
    is_div ? op_div :
    is_log ? op_log :
    is_bit ? op_bit : OP_NONE;

  // Anything outside the decoded cells is flagged illegal
  wire logic illegal_d = op_d == OP_NONE;

  // Operand fields read zero outside their own forms
  wire eod_dec_t dec_d = '{
    op:             op_d,
    reg_form:       is_reg_b,
    abs_form:       is_abs_b,
    reg_field:      is_reg_b ? byte2[7:4] : NIB_0,
    abs_addr_field: is_abs_b ? byte2 : '0
  };

  // Operand access kind per form
  wire logic is_bread = op_d inside {OP_BIT_TEST, OP_BIT_OR, OP_BIT_OR_INV,
                        OP_BIT_XOR, OP_BIT_XOR_INV, OP_BIT_AND,
                        OP_BIT_AND_INV, OP_BIT_LOAD, OP_BIT_LOAD_INV};
  wire logic is_brmw  = op_d inside {OP_BIT_SET, OP_BIT_NOT, OP_BIT_CLR,
                        OP_BIT_STORE, OP_BIT_STORE_INV};
  wire logic is_word  = op_d == OP_LOAD_CTL || op_d == OP_STORE_CTL;
  wire logic is_short = op_d == OP_SMUL_B || op_d == OP_SDIV_B;
  wire logic is_long  = op_d == OP_SMUL_W || op_d == OP_SDIV_W;

  // Fixed per-form counts
  // Branch and stack cycles never occur in these forms
  wire eod_cnt_t cnt_d = '{
    fetch:    illegal_d ? C_ZERO : C_FETCH_4B,
    branch:   C_ZERO,
    stack:    C_ZERO,
    byte_acc: is_bread ? C_BYTE_RD : is_brmw ? C_BYTE_RMW : C_ZERO,
    word_acc: is_word ? C_CTL_WORD : C_ZERO,
    internal: is_short ? C_MUL_B_N : is_long ? C_MUL_W_N : C_ZERO
  };

  // Byte access cost depends on location
  wire logic [COST_W-1:0] s_byte =
    !byte_periph_i     ? S_BYTE_MEM  :
    byte_periph_slow_i ? S_BYTE_SLOW : S_BYTE_FAST;

  wire logic [TOTAL_W-1:0] part_fetch;
  wire logic [TOTAL_W-1:0] part_branch;
  wire logic [TOTAL_W-1:0] part_stack;
  wire logic [TOTAL_W-1:0] part_byte;
  wire logic [TOTAL_W-1:0] part_word;
  wire logic [TOTAL_W-1:0] part_int;

  eod_cost_mul u_fetch (
    .count_i  (cnt_d.fetch),
    .cost_i   (S_FETCH_MEM),
    .states_o (part_fetch)
  );
  eod_cost_mul u_branch (
    .count_i  (cnt_d.branch),
    .cost_i   (S_BRANCH_MEM),
    .states_o (part_branch)
  );
  eod_cost_mul u_stack (
    .count_i  (cnt_d.stack),
    .cost_i   (S_STACK_MEM),
    .states_o (part_stack)
  );
  eod_cost_mul u_byte (
    .count_i  (cnt_d.byte_acc),
    .cost_i   (s_byte),
    .states_o (part_byte)
  );
  eod_cost_mul u_word (
    .count_i  (cnt_d.word_acc),
    .cost_i   (S_WORD_MEM),
    .states_o (part_word)
  );
  eod_cost_mul u_int (
    .count_i  (cnt_d.internal),
    .cost_i   (S_INTERNAL),
    .states_o (part_int)
  );

  // Largest total stays well inside the output width
  wire logic [TOTAL_W-1:0] total_d = part_fetch + part_branch + part_stack
                                   + part_byte + part_word + part_int;

  // Result registers
  logic               valid_q;
  logic               illegal_q;
  eod_dec_t           dec_q;
  eod_cnt_t           cnt_q;
  logic [TOTAL_W-1:0] total_q;

  // Strobe: one cycle per taken word
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= instr_valid_i;
    end
  end

  // Payload holds until the next taken word
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      illegal_q <= 1'b0;
      dec_q     <= '0;
      cnt_q     <= '0;
      total_q   <= '0;
    end else if (instr_valid_i) begin
      illegal_q <= illegal_d;
      dec_q     <= dec_d;
      cnt_q     <= cnt_d;
      total_q   <= total_d;
    end
  end

  assign dec_valid_o   = valid_q;
  assign dec_illegal_o = illegal_q;
  assign dec_o         = dec_q;
  assign cnt_o         = cnt_q;
  assign exec_states_o = total_q;

endmodule

// File: src/eod_pkg.sv
package eod_pkg;

  // Instruction, count, cost and total widths
  localparam int unsigned INSTR_W   = 32;
  localparam int unsigned CNT_W     = 5;
  localparam int unsigned COST_W    = 2;
  localparam int unsigned TOTAL_W   = 10;

  // Prefix bytes and third-byte upper nibbles
  localparam logic [7:0] PFX_FIRST  = 8'h01;
  localparam logic [7:0] PFX_CTL    = 8'h40;
  localparam logic [7:0] PFX_MUL    = 8'hc0;
  localparam logic [7:0] PFX_DIV    = 8'hd0;
  localparam logic [7:0] PFX_LOG    = 8'hf0;
  localparam logic [7:0] BIT_REG_T  = 8'h7c;
  localparam logic [7:0] BIT_REG_M  = 8'h7d;
  localparam logic [7:0] BIT_ABS_T  = 8'h7e;
  localparam logic [7:0] BIT_ABS_M  = 8'h7f;
  localparam logic [3:0] NIB_0      = 4'h0;
  localparam logic [3:0] NIB_5      = 4'h5;
  localparam logic [3:0] NIB_6      = 4'h6;
  localparam logic [3:0] NIB_7      = 4'h7;

  // Third-byte lower nibbles
  localparam logic [3:0] CL_MUL_B   = 4'h0;
  localparam logic [3:0] CL_DIV_B   = 4'h1;
  localparam logic [3:0] CL_MUL_W   = 4'h2;
  localparam logic [3:0] CL_DIV_W   = 4'h3;
  localparam logic [3:0] CL_TEST    = 4'h3;
  localparam logic [3:0] CL_OR      = 4'h4;
  localparam logic [3:0] CL_XOR     = 4'h5;
  localparam logic [3:0] CL_AND     = 4'h6;
  localparam logic [3:0] CL_LOAD    = 4'h7;
  localparam logic [3:0] CL_SET     = 4'h0;
  localparam logic [3:0] CL_NOT     = 4'h1;
  localparam logic [3:0] CL_CLR     = 4'h2;
  localparam logic [3:0] CL_STORE   = 4'h7;

  // States per cycle type
  localparam logic [COST_W-1:0] S_FETCH_MEM  = 2'h2;
  localparam logic [COST_W-1:0] S_INTERNAL   = 2'h1;
  localparam logic [COST_W-1:0] S_BYTE_FAST  = 2'h2;
  localparam logic [COST_W-1:0] S_BYTE_SLOW  = 2'h3;
  localparam logic [COST_W-1:0] S_OTHER_DEF  = 2'h2;

  // Per-form cycle counts
  localparam logic [CNT_W-1:0] C_ZERO      = 5'h00;
  localparam logic [CNT_W-1:0] C_FETCH_4B  = 5'h02;
  localparam logic [CNT_W-1:0] C_BYTE_RD   = 5'h01;
  localparam logic [CNT_W-1:0] C_BYTE_RMW  = 5'h02;
  localparam logic [CNT_W-1:0] C_CTL_WORD  = 5'h01;
  localparam logic [CNT_W-1:0] C_MUL_B_N   = 5'h0c;
  localparam logic [CNT_W-1:0] C_MUL_W_N   = 5'h14;

  typedef enum logic [4:0] {
    OP_NONE          = 5'h00,
    OP_SMUL_B        = 5'h01,
    OP_SMUL_W        = 5'h02,
    OP_SDIV_B        = 5'h03,
    OP_SDIV_W        = 5'h04,
    OP_OR_L          = 5'h05,
    OP_XOR_L         = 5'h06,
    OP_AND_L         = 5'h07,
    OP_LOAD_CTL      = 5'h08,
    OP_STORE_CTL     = 5'h09,
    OP_BIT_TEST      = 5'h0a,
    OP_BIT_OR        = 5'h0b,
    OP_BIT_OR_INV    = 5'h0c,
    OP_BIT_XOR       = 5'h0d,
    OP_BIT_XOR_INV   = 5'h0e,
    OP_BIT_AND       = 5'h0f,
    OP_BIT_AND_INV   = 5'h10,
    OP_BIT_LOAD      = 5'h11,
    OP_BIT_LOAD_INV  = 5'h12,
    OP_BIT_SET       = 5'h13,
    OP_BIT_NOT       = 5'h14,
    OP_BIT_CLR       = 5'h15,
    OP_BIT_STORE     = 5'h16,
    OP_BIT_STORE_INV = 5'h17
  } eod_op_t;

  typedef struct packed {
    logic [CNT_W-1:0] fetch;
    logic [CNT_W-1:0] branch;
    logic [CNT_W-1:0] stack;
    logic [CNT_W-1:0] byte_acc;
    logic [CNT_W-1:0] word_acc;
    logic [CNT_W-1:0] internal;
  } eod_cnt_t;

  typedef struct packed {
    eod_op_t    op;
    logic       reg_form;
    logic       abs_form;
    logic [3:0] reg_field;
    logic [7:0] abs_addr_field;
  } eod_dec_t;

endpackage

// File: tb/eod_decoder_monitor.sv
`timescale 1ns/10ps
module eod_decoder_monitor
  import eod_pkg::*;
#(
  parameter logic [COST_W-1:0] S_BRANCH_MEM = S_OTHER_DEF,
  parameter logic [COST_W-1:0] S_STACK_MEM  = S_OTHER_DEF,
  parameter logic [COST_W-1:0] S_BYTE_MEM   = S_OTHER_DEF,
  parameter logic [COST_W-1:0] S_WORD_MEM   = S_OTHER_DEF
)
(
  input wire logic               clk_i,
  input wire logic               srst_i,
  input wire logic               instr_valid_i,
  input wire logic [INSTR_W-1:0] instr_i,
  input wire logic               byte_periph_i,
  input wire logic               byte_periph_slow_i,
  input wire logic               dec_valid_o,
  input wire logic               dec_illegal_o,
  input wire eod_dec_t           dec_o,
  input wire eod_cnt_t           cnt_o,
  input wire logic [TOTAL_W-1:0] exec_states_o
);
  logic [INSTR_W-1:0] iq_q;
  logic               p_q;
  logic               s_q;
  logic [COST_W-1:0]  bc;
  logic [TOTAL_W-1:0] sum;
  logic [TOTAL_W-1:0] f2;
  always_ff @(posedge clk_i) begin
    if (instr_valid_i) begin
      iq_q <= instr_i;
      p_q  <= byte_periph_i;
      s_q  <= byte_periph_slow_i;
    end
  end
  assign bc  = p_q ? (s_q ? S_BYTE_SLOW : S_BYTE_FAST) : S_BYTE_MEM;
  assign f2  = TOTAL_W'(cnt_o.fetch) * S_FETCH_MEM;
  assign sum = f2 + TOTAL_W'(cnt_o.branch) * S_BRANCH_MEM
             + TOTAL_W'(cnt_o.stack) * S_STACK_MEM
             + TOTAL_W'(cnt_o.byte_acc) * bc
             + TOTAL_W'(cnt_o.word_acc) * S_WORD_MEM
             + TOTAL_W'(cnt_o.internal) * S_INTERNAL;
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  chk_answer_latency: assert property (instr_valid_i |=> dec_valid_o)
    else $error("no answer one cycle after a taken word");
  chk_total_sum: assert property (
    dec_valid_o |-> exec_states_o == sum)
    else $error("total is not the weighted sum of counts");
  chk_muldiv_cost: assert property (
    dec_valid_o && dec_o.op inside {OP_SMUL_B, OP_SMUL_W, OP_SDIV_B,
    OP_SDIV_W} |-> exec_states_o == f2 + TOTAL_W'(cnt_o.internal))
    else $error("fetch or internal cost wrong");
  chk_periph_cost: assert property (
    dec_valid_o && p_q && dec_o.abs_form |-> exec_states_o ==
    f2 + TOTAL_W'(cnt_o.byte_acc) * (s_q ? 3 : 2))
    else $error("peripheral byte cost wrong");
  chk_select_bit: assert property (
    instr_valid_i && instr_i[31:12] == 20'h01406 && instr_i[8] |=>
    dec_o.op == ($past(instr_i[7]) ? OP_STORE_CTL : OP_LOAD_CTL))
    else $error("shared cell picked wrong operation");
  chk_reg_field: assert property (
    dec_valid_o && dec_o.reg_form |->
    dec_o.reg_field == iq_q[23:20] && iq_q[31:25] == 7'h3e)
    else $error("register field wrong");
  chk_abs_field: assert property (
    dec_valid_o && dec_o.abs_form |->
    dec_o.abs_addr_field == iq_q[23:16] && iq_q[31:25] == 7'h3f)
    else $error("absolute address field wrong");
  chk_prefix_route: assert property (
    dec_valid_o && dec_o.op inside {OP_SMUL_B, OP_SMUL_W} |->
    iq_q[31:16] == {PFX_FIRST, PFX_MUL})
    else $error("multiply from wrong prefix");
  chk_illegal_flag: assert property (
    dec_valid_o |-> dec_illegal_o == (dec_o.op == OP_NONE))
    else $error("illegal flag disagrees with op");
  chk_hold_out: assert property (
    !instr_valid_i |=> !dec_valid_o && $stable(exec_states_o)
    && $stable(cnt_o) && $stable(dec_o) && $stable(dec_illegal_o))
    else $error("outputs moved without a word");
endmodule
bind eod_decoder eod_decoder_monitor #(
  .S_BRANCH_MEM(S_BRANCH_MEM),
  .S_STACK_MEM (S_STACK_MEM),
  .S_BYTE_MEM  (S_BYTE_MEM),
  .S_WORD_MEM  (S_WORD_MEM)
) u_eod_decoder_monitor (.*);

// File: tb/eod_decoder_tb_top.sv
`timescale 1ns/10ps
module eod_decoder_tb_top;
  import eod_pkg::*;
  logic               clk_i = 1'b0;
  logic               srst_i = 1'b1;
  logic               vld = 1'b0;
  logic [INSTR_W-1:0] ins = 32'h0;
  logic               per;
  logic               slo;
  logic               dv;
  logic               ill;
  eod_dec_t           dec;
  eod_cnt_t           cnt;
  logic [TOTAL_W-1:0] ex;
  int                 num_errors = 0;
  int                 comparisons = 0;
  int                 cyc = 0;
  always #10 clk_i = ~clk_i;
  eod_mem_model u_eod_mem_model (.addr_i(ins[23:16]), .periph_o(per),
    .slow_o(slo));
  eod_decoder u_eod_decoder (.clk_i(clk_i), .srst_i(srst_i),
    .instr_valid_i(vld), .instr_i(ins), .byte_periph_i(per),
    .byte_periph_slow_i(slo), .dec_valid_o(dv), .dec_illegal_o(ill),
    .dec_o(dec), .cnt_o(cnt), .exec_states_o(ex));
  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  task automatic bad(logic [31:0] got, logic [31:0] exp);
    num_errors++;
    $display("BAD %0t got %h want %h", $time, got, exp);
  endtask
  task automatic cmp_flag(logic got, logic exp);
    comparisons++;
    if (got !== exp) begin
      bad(got, exp);
    end
  endtask
  task automatic cmp_op(eod_op_t got, eod_op_t exp);
    comparisons++;
    if (got !== exp) begin
      bad(got, exp);
    end
  endtask
  task automatic cmp_val(logic [31:0] got, logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad(got, exp);
    end
  endtask
  // One word in, then op, flag, total and valid pulse checked
  task automatic run(logic [31:0] w, eod_op_t op, int b, int c, int n);
    @(posedge clk_i) #1;
    vld = 1'b1;
    ins = w;
    @(posedge clk_i) #1;
    vld = 1'b0;
    cmp_flag(dv, 1'b1);
    cmp_op(dec.op, op);
    cmp_flag(ill, op == OP_NONE);
    cmp_val(ex, (op == OP_NONE) ? 0 : 4 + b * c + n);
  endtask
  task automatic t_prefix();
    run(32'h01c05000, OP_SMUL_B, 0, 0, 12);
    run(32'h01c05200, OP_SMUL_W, 0, 0, 20);
    cmp_val(cnt.internal, 20);
    run(32'h01d05100, OP_SDIV_B, 0, 0, 12);
    run(32'h01d05300, OP_SDIV_W, 0, 0, 20);
    run(32'h01c05100, OP_NONE, 0, 0, 0);
    run(32'h01f06400, OP_OR_L, 0, 0, 0);
    run(32'h01f06500, OP_XOR_L, 0, 0, 0);
    run(32'h01f06600, OP_AND_L, 0, 0, 0);
    cmp_val(cnt.fetch, 2);
  endtask
  task automatic t_select();
    run(32'h01406700, OP_LOAD_CTL, 1, 2, 0);
    cmp_val(cnt.word_acc, 1);
    run(32'h01406780, OP_STORE_CTL, 1, 2, 0);
    run(32'h01406600, OP_NONE, 0, 0, 0);
    run(32'h7c507480, OP_BIT_OR_INV, 1, 2, 0);
    run(32'h7c107400, OP_BIT_OR, 1, 2, 0);
    run(32'h7c107580, OP_BIT_XOR_INV, 1, 2, 0);
    run(32'h7c107500, OP_BIT_XOR, 1, 2, 0);
    run(32'h7c107680, OP_BIT_AND_INV, 1, 2, 0);
    run(32'h7c107600, OP_BIT_AND, 1, 2, 0);
    run(32'h7c107780, OP_BIT_LOAD_INV, 1, 2, 0);
    run(32'h7d306700, OP_BIT_STORE, 2, 2, 0);
    run(32'h7d306780, OP_BIT_STORE_INV, 2, 2, 0);
    run(32'h7d307700, OP_NONE, 0, 0, 0);
  endtask
  task automatic t_fields();
    run(32'h7ca06300, OP_BIT_TEST, 1, 2, 0);
    cmp_val(dec.reg_field, 4'ha);
    cmp_flag(dec.reg_form, 1'b1);
    run(32'h7c517400, OP_NONE, 0, 0, 0);
    cmp_val(dec.reg_field, 4'h0);
    run(32'h7ef87480, OP_BIT_OR_INV, 1, 3, 0);
    cmp_val(dec.abs_addr_field, 8'hf8);
    cmp_flag(dec.abs_form, 1'b1);
    run(32'h7ef06300, OP_BIT_TEST, 1, 2, 0);
    run(32'h7ff06000, OP_BIT_SET, 2, 2, 0);
    cmp_val(cnt.byte_acc, 2);
    run(32'h7ffa7100, OP_BIT_NOT, 2, 3, 0);
    run(32'h7f206200, OP_BIT_CLR, 2, 2, 0);
    run(32'h7e207700, OP_BIT_LOAD, 1, 2, 0);
    cmp_val(dec.abs_addr_field, 8'h20);
    cmp_flag(dec.reg_form, 1'b0);
  endtask
  task automatic t_illegal();
    run(32'h12345678, OP_NONE, 0, 0, 0);
    cmp_flag(ill, 1'b1);
    cmp_val(cnt, 0);
    @(posedge clk_i) #1;
    cmp_flag(dv, 1'b0);
    cmp_flag(ill, 1'b1);
  endtask
  // Reset in mid-run clears the held result, then decoding resumes
  task automatic t_reset();
    run(32'h01c05200, OP_SMUL_W, 0, 0, 20);
    srst_i = 1'b1;
    @(posedge clk_i) #1;
    cmp_flag(dv, 1'b0);
    cmp_op(dec.op, OP_NONE);
    cmp_flag(ill, 1'b0);
    cmp_val(ex, 0);
    @(posedge clk_i) #1;
    srst_i = 1'b0;
    run(32'h7d207100, OP_BIT_NOT, 2, 2, 0);
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    #1 srst_i = 1'b0;
    t_prefix();
    t_select();
    t_fields();
    t_illegal();
    t_reset();
    tally_and_finish();
  end
endmodule

// File: tb/eod_mem_model.sv
`timescale 1ns/10ps
// Address map: top sixteen bytes are peripherals
module eod_mem_model (
  // Operand address
  input  wire logic [7:0] addr_i,
  // Location
  output logic            periph_o,
  output logic            slow_o
);
  assign periph_o = (addr_i[7:4] == 4'hf);
  assign slow_o   = periph_o & addr_i[3];
endmodule
